// [wab_des_model.sv]
// Deserializer stand-in: words and code error flags
`timescale 1ns/1ns
module wab_des_model #(parameter W = 20) (
  input wire clk_in,
  input wire [1:0] sel_in,
  input wire bad_in,
  output reg [W-1:0] data_out = 0,
  output reg err_out = 0
);
  wire [W-1:0] pat = {(W/10){10'h17C}};
  always @(posedge clk_in) begin
    err_out <= bad_in;
    case (sel_in)
      2'h0: data_out <= {(W/2){2'h1}};
      2'h1: data_out <= {W{1'b0}};
      // Comma stream 3 bits off the word edge, forcing a real search
      default: data_out <= W'({pat, pat} >> 3);
    endcase
  end
endmodule

// [wab_map.vh]
// Constants for the word aligner and transmit bit slip block
`ifndef WAB_MAP_VH
`define WAB_MAP_VH
`define WAB_MODE_SLIP 2'h0
`define WAB_MODE_SYNC 2'h1
`define WAB_MODE_MANUAL 2'h2
`define WAB_ACQ_DEFAULT 9'h003
`define WAB_LOSE_DEFAULT 9'h003
`define WAB_GOOD_DEFAULT 9'h004
`define WAB_RUN_DEFAULT 6'h3F
`define WAB_PAT_DEFAULT 40'h000000017C
`define WAB_PLEN_DEFAULT 6'h0A
`define WAB_ST_LOSS 2'h0
`define WAB_ST_ACQ 2'h1
`define WAB_ST_LOCK 2'h2
`define WAB_ST_ERR 2'h3
`endif

// [wab_word_aligner.v]
// Receive word aligner with run length check and transmit bit slip
// What this block does
// R01 - Delay transmit data by selected slip bits
// R02 - Manual slip shifts boundary one bit
// R03 - Each slip drops the oldest bit
// R04 - Sync mode only for 8B/10B coded data
// R05 - Sync mode takes 10 or 20 bits
// R06 - Acquire and lose hysteresis like XAUI
// R07 - Cpri setting selects deterministic latency alignment
// R08 - Pattern align acts on rising edge
// R09 - Pattern length selectable, matched LSB first
// R10 - Lock after programmed count of patterns
// R11 - Lose sync after programmed error count
// R12 - Good code run decrements error counter
// R13 - Error count zero returns to lock
// R14 - Flag run of identical bits over limit
// R15 - Build options include or omit optional ports
// R16 - Synchronise requests, act once per edge
`timescale 1ns/1ns
`include "wab_map.vh"
module wab_word_aligner #(
  parameter W = 20,
  parameter HAS_PATTERN_ALIGN = 1,
  parameter HAS_SYNC_SIZE = 1,
  parameter HAS_SLIP = 1,
  parameter HAS_BOUNDARY = 1,
  parameter HAS_RUNLEN = 1,
  parameter [39:0] PATTERN = `WAB_PAT_DEFAULT,
  parameter [5:0] PATTERN_LEN = `WAB_PLEN_DEFAULT,
  parameter [8:0] ACQ_COUNT = `WAB_ACQ_DEFAULT,
  parameter [8:0] LOSE_COUNT = `WAB_LOSE_DEFAULT,
  parameter [8:0] GOOD_COUNT = `WAB_GOOD_DEFAULT,
  parameter [5:0] RUN_LIMIT = `WAB_RUN_DEFAULT
) (
  input wire clk_in,
  input wire resetn_in,
  input wire [1:0] mode_in,
  input wire cpri_mode_in,
  input wire wide_path_in,
  input wire [W-1:0] rx_data_in,
  input wire rx_code_err_in,
  input wire rx_disp_err_in,
  input wire rx_slip_request_input_in,
  input wire rx_pattern_align_port_in,
  input wire rx_sync_size_select_in,
  input wire [W-1:0] tx_data_in,
  input wire [4:0] tx_slip_amount_in,
  output reg [W-1:0] rx_data_out,
  output reg rx_sync_locked_out,
  output reg rx_pattern_found_out,
  output reg rx_det_latency_out,
  output reg [4:0] rx_boundary_position_out,
  output reg rx_runlen_violation_sig_out,
  output reg [W-1:0] tx_data_out
);
  localparam [4:0] WL = W - 1;
  reg [2*W-1:0] hist_q;
  reg [4:0] pos_q;
  reg [1:0] slip_sync_q;
  reg slip_prev_q;
  reg [1:0] pat_sync_q;
  reg pat_prev_q;
  reg hunt_q;
  reg [1:0] st_q;
  reg [8:0] cnt_q;
  reg [8:0] good_q;
  reg [8:0] err_q;
  reg [5:0] run_q;
  reg last_bit_q;
  reg [W-1:0] tx_prev_q;
  wire [2*W-1:0] hist_d = {rx_data_in, hist_q[2*W-1:W]};
  wire [W-1:0] word = hist_q[pos_q +: W];
  wire [2*W-1:0] tx_cat = {tx_data_in, tx_prev_q};
  // Optional inputs tie off when omitted
  wire slip_pin = (HAS_SLIP != 0) ? rx_slip_request_input_in : 1'b0; // see R15
  wire pat_pin = (HAS_PATTERN_ALIGN != 0) ? rx_pattern_align_port_in : 1'b0; // see R15
  wire size_sel = (HAS_SYNC_SIZE != 0) ? rx_sync_size_select_in : 1'b0; // see R15
  wire slip_rise = slip_sync_q[1] & ~slip_prev_q; // see R16
  wire pat_rise = pat_sync_q[1] & ~pat_prev_q; // see R16
  wire [39:0] pat_mask = (40'h1 << PATTERN_LEN) - 40'h1;
  wire [5:0] plen = (PATTERN_LEN > W) ? W[5:0] : PATTERN_LEN;
  // Narrow path ignores upper half unless size select is set; sync needs 10 or 20 bits
  wire [4:0] span = (wide_path_in || size_sel) ? WL : 5'h09; // see R05
  wire code_bad = rx_code_err_in | rx_disp_err_in;
  reg [4:0] match_pos;
  reg match_any;
  reg [5:0] run_d;
  reg bit_d;
  integer i;
  integer b;
  reg [4:0] pos_d;
  reg hunt_d;
  reg found_d;
  reg [1:0] st_d;
  reg [8:0] cnt_d;
  reg [8:0] good_d;
  reg [8:0] err_d;
  reg [W-1:0] txo_d;
  reg lock_d;
  reg runv_d;
  reg [4:0] bpos_d;
  reg dlat_d;
  // Pattern compared LSB first at every offset from 0 up to span
  always @* begin
    match_pos = 5'h00;
    match_any = 1'b0;
    for (i = W - 1; i >= 0; i = i - 1) begin
      if ((({{(40-W){1'b0}}, hist_d[i +: W]} ^ PATTERN) & pat_mask) == 40'h0
          && plen != 6'h0 && i[4:0] <= span) begin // see R09
        match_pos = i[4:0];
        match_any = 1'b1;
      end
    end
  end
  // Run length across the whole aligned word
  always @* begin
    run_d = run_q;
    bit_d = last_bit_q;
    for (b = 0; b < W; b = b + 1) begin
      if (word[b] == bit_d) begin
        if (run_d != 6'h3F) begin
          run_d = run_d + 6'h01;
        end
      end else begin
        run_d = 6'h01;
      end
      bit_d = word[b];
    end
  end
  // Boundary offset: slip, pattern hunt or sync search
  always @* begin
    pos_d = pos_q;
    hunt_d = hunt_q;
    found_d = 1'b0;
    // Offset grows so the oldest bit drops out
    if (mode_in == `WAB_MODE_SLIP && slip_rise) begin // see R02
      pos_d = (pos_q == WL) ? 5'h00 : pos_q + 5'h01; // see R03
    end
    // Edge arms a hunt; first match fixes the boundary
    if (mode_in == `WAB_MODE_MANUAL) begin
      if (pat_rise) begin // see R08
        hunt_d = 1'b1;
      end else if (hunt_q && match_any) begin
        hunt_d = 1'b0;
        pos_d = match_pos;
        found_d = 1'b1;
      end
    end else begin
      hunt_d = 1'b0;
    end
    // Sync search takes the first match, then only confirms it
    if (mode_in == `WAB_MODE_SYNC) begin
      if (st_q == `WAB_ST_LOSS && match_any) begin
        pos_d = match_pos;
        found_d = 1'b1;
      end else if (st_q == `WAB_ST_ACQ && !code_bad) begin
        if (match_any && match_pos == pos_q) begin
          found_d = 1'b1;
        end
      end
    end
  end
  // Sync state machine; caller must feed 8B/10B code status
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    good_d = good_q;
    err_d = err_q;
    if (mode_in != `WAB_MODE_SYNC) begin // see R04
      st_d = `WAB_ST_LOSS;
    end else begin
      case (st_q)
        `WAB_ST_LOSS: begin
          if (match_any) begin
            cnt_d = 9'h001;
            st_d = (ACQ_COUNT <= 9'h001) ? `WAB_ST_LOCK : `WAB_ST_ACQ; // see R10
          end
        end
        `WAB_ST_ACQ: begin
          // Any bad code restarts the hunt
          if (code_bad) begin
            st_d = `WAB_ST_LOSS; // see R06
          end else if (match_any && match_pos == pos_q) begin
            cnt_d = cnt_q + 9'h001;
            if (cnt_q + 9'h001 >= ACQ_COUNT) begin
              st_d = `WAB_ST_LOCK; // see R10
            end
          end
        end
        `WAB_ST_LOCK: begin
          if (code_bad) begin
            err_d = 9'h001;
            good_d = 9'h000;
            st_d = (LOSE_COUNT <= 9'h001) ? `WAB_ST_LOSS : `WAB_ST_ERR; // see R11
          end
        end
        `WAB_ST_ERR: begin
          // Good run restarts on every bad code
          if (code_bad) begin
            good_d = 9'h000;
            err_d = err_q + 9'h001;
            if (err_q + 9'h001 >= LOSE_COUNT) begin
              st_d = `WAB_ST_LOSS; // see R11
            end
          end else if (good_q + 9'h001 >= GOOD_COUNT) begin
            good_d = 9'h000;
            err_d = err_q - 9'h001; // see R12
            if (err_q == 9'h001) begin
              st_d = `WAB_ST_LOCK; // see R13
            end
          end else begin
            good_d = good_q + 9'h001;
          end
        end
        default: st_d = `WAB_ST_LOSS;
      endcase
    end
  end
  // Next values of the registered outputs
  always @* begin
    lock_d = (mode_in == `WAB_MODE_SYNC) &&
             (st_q == `WAB_ST_LOCK || st_q == `WAB_ST_ERR);
    dlat_d = (mode_in == `WAB_MODE_SYNC) && cpri_mode_in; // see R07
    bpos_d = 5'h00;
    if (HAS_BOUNDARY != 0) begin // see R15
      bpos_d = pos_q;
    end
    // Limit 0 flags any bit at all
    runv_d = (HAS_RUNLEN != 0) && (run_d > RUN_LIMIT); // see R14
    // Slip amount picks a window across two words
    txo_d = tx_cat[(W[5:0] - {1'b0, tx_slip_amount_in}) +: W]; // see R01
  end
  // Pin synchronisers; only the second stage is read
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      slip_sync_q <= 2'h0;
      slip_prev_q <= 1'b0;
      pat_sync_q <= 2'h0;
      pat_prev_q <= 1'b0;
    end else begin
      slip_sync_q <= {slip_sync_q[0], slip_pin}; // see R16
      slip_prev_q <= slip_sync_q[1];
      pat_sync_q <= {pat_sync_q[0], pat_pin}; // see R16
      pat_prev_q <= pat_sync_q[1];
    end
  end
  // Receive history and run length state
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      hist_q <= {2*W{1'b0}};
      run_q <= 6'h00;
      last_bit_q <= 1'b0;
    end else begin
      hist_q <= hist_d;
      run_q <= run_d;
      last_bit_q <= word[W-1];
    end
  end
  // Previous transmit word for the slip window
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      tx_prev_q <= {W{1'b0}};
    end else begin
      tx_prev_q <= tx_data_in;
    end
  end
  // Alignment and sync state
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      pos_q <= 5'h00;
      hunt_q <= 1'b0;
      st_q <= `WAB_ST_LOSS;
      cnt_q <= 9'h000;
      good_q <= 9'h000;
      err_q <= 9'h000;
    end else begin
      pos_q <= pos_d;
      hunt_q <= hunt_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      good_q <= good_d;
      err_q <= err_d;
    end
  end
  // Every output straight from a flip-flop
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      rx_data_out <= {W{1'b0}};
      rx_sync_locked_out <= 1'b0;
      rx_pattern_found_out <= 1'b0;
      rx_det_latency_out <= 1'b0;
      rx_boundary_position_out <= 5'h00;
      rx_runlen_violation_sig_out <= 1'b0;
      tx_data_out <= {W{1'b0}};
    end else begin
      rx_data_out <= word;
      rx_sync_locked_out <= lock_d;
      rx_pattern_found_out <= found_d;
      rx_det_latency_out <= dlat_d;
      rx_boundary_position_out <= bpos_d;
      rx_runlen_violation_sig_out <= runv_d;
      tx_data_out <= txo_d;
    end
  end
endmodule

// [wab_word_aligner_chk.sv]
// Port checker for the word aligner
`timescale 1ns/1ns
`include "wab_map.vh"
module wab_word_aligner_chk #(parameter W = 20) (
  input wire clk_in,
  input wire resetn_in,
  input wire [1:0] mode_in,
  input wire cpri_mode_in,
  input wire [W-1:0] rx_data_in,
  input wire rx_code_err_in,
  input wire rx_slip_request_input_in,
  input wire [W-1:0] tx_data_in,
  input wire [4:0] tx_slip_amount_in,
  input wire rx_sync_locked_out,
  input wire rx_pattern_found_out,
  input wire rx_det_latency_out,
  input wire [4:0] rx_boundary_position_out,
  input wire rx_runlen_violation_sig_out,
  input wire [W-1:0] tx_data_out
);
  reg [1:0] up_q = 2'h0;
  wire [4:0] p = rx_boundary_position_out;
  wire slp = mode_in == `WAB_MODE_SLIP;
  wire lk = rx_sync_locked_out;
  wire fd = rx_pattern_found_out;
  always @(posedge clk_in) up_q <= {up_q[0], resetn_in};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  AST_TXS: assert property (up_q == 2'h3 |=> tx_data_out ==
    W'({$past(tx_data_in), $past(tx_data_in, 2)} >> (W - $past(tx_slip_amount_in))))
    else $error("tx slip wrong");
  AST_STEP: assert property (slp && $past(slp) && p != $past(p) |->
    p == ($past(p) == W - 1 ? 5'h00 : $past(p) + 5'h01)) else $error("slip step");
  AST_ONCE: assert property ((slp && rx_slip_request_input_in) [*8] |=> $stable(p))
    else $error("slip repeated");
  AST_RUNV: assert property (rx_data_in == 0 [*4] |-> ##[1:3] rx_runlen_violation_sig_out)
    else $error("run missed");
  AST_RUNOK: assert property (rx_data_in == {(W/2){2'h1}} [*4] |->
    !rx_runlen_violation_sig_out) else $error("false run");
  AST_DLAT: assert property (up_q[0] |-> rx_det_latency_out ==
    $past(mode_in == `WAB_MODE_SYNC && cpri_mode_in)) else $error("latency mode");
  AST_LOSE: assert property ((lk && rx_code_err_in) [*3] |-> ##[1:3] !lk)
    else $error("lock kept");
  AST_PULS: assert property (mode_in == `WAB_MODE_MANUAL && fd |=> !fd)
    else $error("found not pulse");
  cover property (slp && $changed(p));
  cover property ($rose(lk));
  cover property ($fell(lk));
  cover property (fd);
endmodule
bind wab_word_aligner wab_word_aligner_chk #(.W(W)) u_chk (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .mode_in(mode_in),
  .cpri_mode_in(cpri_mode_in),
  .rx_data_in(rx_data_in),
  .rx_code_err_in(rx_code_err_in),
  .rx_slip_request_input_in(rx_slip_request_input_in),
  .tx_data_in(tx_data_in),
  .tx_slip_amount_in(tx_slip_amount_in),
  .rx_sync_locked_out(rx_sync_locked_out),
  .rx_pattern_found_out(rx_pattern_found_out),
  .rx_det_latency_out(rx_det_latency_out),
  .rx_boundary_position_out(rx_boundary_position_out),
  .rx_runlen_violation_sig_out(rx_runlen_violation_sig_out),
  .tx_data_out(tx_data_out)
);

// [wab_word_aligner_tb.sv]
// Self-checking bench for the word aligner
`timescale 1ns/1ns
`include "wab_map.vh"
module wab_word_aligner_tb;
  reg clk_in = 0;
  reg resetn_in = 0;
  reg cpri = 0;
  reg slip = 0;
  reg pal = 0;
  reg bad = 0;
  reg seen = 0;
  reg wide = 1;
  reg disp = 0;
  reg ssel = 0;
  reg [1:0] mode = `WAB_MODE_SLIP;
  reg [1:0] sel = 2'h0;
  reg [19:0] txd = 0;
  reg [4:0] amt = 0;
  reg [44:0] rows [0:4];
  wire [19:0] rxd, rxo, txo;
  wire err, lk, fd, dl, rv;
  wire [4:0] pos;
  integer num_errors = 0, checked = 0, cyc = 0, i;
  initial forever #5 clk_in = ~clk_in;
  wab_des_model #(.W(20)) src (.clk_in(clk_in), .sel_in(sel), .bad_in(bad),
    .data_out(rxd), .err_out(err));
  wab_word_aligner #(.W(20), .RUN_LIMIT(6'h05)) uut (.clk_in(clk_in), .resetn_in(resetn_in),
    .mode_in(mode), .cpri_mode_in(cpri), .wide_path_in(wide), .rx_data_in(rxd),
    .rx_code_err_in(err), .rx_disp_err_in(disp), .rx_slip_request_input_in(slip),
    .rx_pattern_align_port_in(pal), .rx_sync_size_select_in(ssel), .tx_data_in(txd),
    .tx_slip_amount_in(amt), .rx_data_out(rxo), .rx_sync_locked_out(lk),
    .rx_pattern_found_out(fd), .rx_det_latency_out(dl),
    .rx_boundary_position_out(pos), .rx_runlen_violation_sig_out(rv), .tx_data_out(txo));
  task check(input ok, input [95:0] msg);
    checked = checked + 1;
    if (!ok) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: %0s", $time, msg);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Pins held 4 high, 6 low: the two-flop synchroniser needs both
  task pulse(input s);
    @(posedge clk_in);
    if (s) slip <= 1; else pal <= 1;
    repeat (4) @(posedge clk_in);
    slip <= 0;
    pal <= 0;
    repeat (6) @(posedge clk_in);
    #1;
  endtask
  task wait_n(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (fd === 1'b1) seen <= 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end
  initial begin
    rows[0] = {20'hF0001, 5'h00, 20'hF0001};
    rows[1] = {20'hF0001, 5'h01, 20'hE0003};
    rows[2] = {20'hF0001, 5'h04, 20'h0001F};
    rows[3] = {20'hF0001, 5'h14, 20'hF0001};
    rows[4] = {20'h00001, 5'h13, 20'h80000};
    wait_n(20);
    check(txo === 0 && lk === 1'b0 && pos === 5'h00, "reset");
    resetn_in <= 1;
    for (i = 0; i < 5; i = i + 1) begin
      {txd, amt} <= rows[i][44:20];
      wait_n(2);
      #1 check(txo === rows[i][19:0], "tx slip");
      @(posedge clk_in);
    end
    for (i = 1; i <= 20; i = i + 1) begin
      pulse(1);
      check(pos === i % 20, "slip pos");
      check(rxo === (i % 2 ? 20'hAAAAA : 20'h55555), "slip data");
    end
    @(posedge clk_in) slip <= 1;
    wait_n(12);
    slip <= 0;
    wait_n(6);
    #1 check(pos === 5'h01, "slip once");
    @(posedge clk_in) mode <= `WAB_MODE_MANUAL;
    sel <= 2'h2;
    wide <= 0;
    pulse(1);
    check(pos === 5'h01, "slip refused");
    pulse(0);
    check(seen === 1'b1 && rxo === {2{10'h17C}}, "pattern");
    @(posedge clk_in) sel <= 2'h1;
    wait_n(6);
    #1 check(rv === 1'b1, "run flag");
    @(posedge clk_in) sel <= 2'h0;
    wait_n(6);
    #1 check(rv === 1'b0, "run clear");
    @(posedge clk_in) mode <= `WAB_MODE_SYNC;
    cpri <= 1;
    sel <= 2'h2;
    ssel <= 1;
    wait_n(20);
    #1 check(lk === 1'b1 && dl === 1'b1, "acquire");
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk_in) bad <= (i != 1);
      wait_n(i == 1 ? 12 : 1);
      bad <= 0;
    end
    wait_n(3);
    #1 check(lk === 1'b1, "decrement");
    @(posedge clk_in) disp <= 1;
    cpri <= 0;
    wait_n(8);
    #1 check(lk === 1'b0 && dl === 1'b0, "lose");
    end_sim;
  end
endmodule
